// ===== hdl/lcd_drive_control.sv
// Segment LCD control register with pin takeover, booster and frame clock
`timescale 1ns/100ps
`default_nettype none

module lcd_drive_control (
	// Clock and reset
	input  wire logic                                CORE_CLK,
	input  wire logic                                NRST,
	// Register port
	input  wire logic [lcd_drive_pkg::ADDR_W-1:0]    REG_ADDR,
	input  wire logic [lcd_drive_pkg::DATA_W-1:0]    REG_WDATA,
	input  wire logic                                REG_WR,
	input  wire logic                                REG_RD,
	output var  logic [lcd_drive_pkg::DATA_W-1:0]    REG_RDATA,
	// Watch clock pin, asynchronous to the core
	input  wire logic                                WATCH_CLK,
	// Port 1 configuration: bit set means LCD function chosen
	input  wire logic [lcd_drive_pkg::PIN_COUNT-1:0] PORT1_CONFIG_HIGH_LOW,
	// Pin function select: bit set means LCD bias/booster function
	output var  logic [lcd_drive_pkg::PIN_COUNT-1:0] BIAS_PIN_SEL,
	// Display drive
	output var  lcd_drive_pkg::duty_t                DUTY_SEL,
	output var  lcd_drive_pkg::bias_t                BIAS_SEL,
	output var  logic                                DISPLAY_ON,
	output var  logic                                BOOSTER_RUN,
	output var  logic                                RESISTOR_BIAS_EN,
	output var  logic                                LCD_FRAME_CLK
);
	import lcd_drive_pkg::*;

	// ==========================================================
	// Register storage and read port
	logic [DATA_W-1:0]    lcd_control_ff;
	logic [DATA_W-1:0]    rdata_ff;
	logic [DATA_W-1:0]    nxt_rdata;
	wire                  hit_ctrl;
	wire                  wr_ctrl;

	assign hit_ctrl  = (REG_ADDR == LCD_CONTROL_ADDR);
	assign wr_ctrl   = REG_WR & hit_ctrl;
	assign nxt_rdata = (REG_RD & hit_ctrl) ? lcd_control_ff : '0;

	always_ff @(posedge CORE_CLK or negedge NRST) begin
		if (!NRST) begin
			lcd_control_ff <= LCD_CONTROL_RST;
		end else if (wr_ctrl) begin
			lcd_control_ff <= REG_WDATA;
		end
	end

	// Unmapped or idle reads return zero
	always_ff @(posedge CORE_CLK or negedge NRST) begin
		if (!NRST) begin
			rdata_ff <= '0;
		end else begin
			rdata_ff <= nxt_rdata;
		end
	end

	assign REG_RDATA = rdata_ff;

	// ==========================================================
	// Field extraction
	wire [1:0]            frame_code;
	wire [2:0]            duty_code;
	wire [1:0]            bias_type;
	wire                  display_bit;

	assign frame_code  = lcd_control_ff[FRAME_SEL_MSB:FRAME_SEL_LSB];
	assign duty_code   = lcd_control_ff[DUTY_BIAS_MSB:DUTY_BIAS_LSB];
	assign bias_type   = lcd_control_ff[BIAS_TYPE_MSB:BIAS_TYPE_LSB];
	assign display_bit = lcd_control_ff[DISPLAY_ON_BIT];

	// ==========================================================
	// Duty and bias decode
	duty_t                duty_ff;
	duty_t                nxt_duty;
	bias_t                bias_ff;
	bias_t                nxt_bias;

	always_comb begin
		nxt_duty = DUTY_HALF;
		nxt_bias = BIAS_HALF;
		if (duty_code[2]) begin // RQ1
			nxt_duty = DUTY_HALF;
			nxt_bias = BIAS_HALF;
		end else begin
			case (duty_code[1:0])
				2'h0: begin
					nxt_duty = DUTY_EIGHTH;
					nxt_bias = BIAS_QUARTER;
				end
				2'h1: begin
					nxt_duty = DUTY_QUARTER;
					nxt_bias = BIAS_THIRD;
				end
				2'h2: begin
					nxt_duty = DUTY_THIRD;
					nxt_bias = BIAS_THIRD;
				end
				default: begin
					nxt_duty = DUTY_THIRD;
					nxt_bias = BIAS_HALF;
				end
			endcase
		end
	end

	always_ff @(posedge CORE_CLK or negedge NRST) begin
		if (!NRST) begin
			duty_ff <= DUTY_EIGHTH;
			bias_ff <= BIAS_QUARTER;
		end else begin
			duty_ff <= nxt_duty;
			bias_ff <= nxt_bias;
		end
	end

	assign DUTY_SEL = duty_ff;
	assign BIAS_SEL = bias_ff;

	// ==========================================================
	// Port 1 pin takeover
	wire [PIN_COUNT-1:0]  cap_pins;
	wire [PIN_COUNT-1:0]  res_pins;
	wire [PIN_COUNT-1:0]  mixed_pins;
	wire [PIN_COUNT-1:0]  nxt_pin_sel;
	logic [PIN_COUNT-1:0] pin_sel_ff;

	assign cap_pins    = PINS_ALL_LCD; // RQ2
	assign res_pins    = PORT1_CONFIG_HIGH_LOW; // RQ4
	assign mixed_pins  = PINS_BIAS_ONLY | (PORT1_CONFIG_HIGH_LOW & PINS_CAP_ONLY); // RQ5 RQ6
	assign nxt_pin_sel = (bias_type == BIAS_TYPE_CAP)   ? cap_pins :
	                     (bias_type == BIAS_TYPE_RES)   ? res_pins :
	                     (bias_type == BIAS_TYPE_MIXED) ? mixed_pins : '0;

	always_ff @(posedge CORE_CLK or negedge NRST) begin
		if (!NRST) begin
			pin_sel_ff <= '0;
		end else begin
			pin_sel_ff <= nxt_pin_sel;
		end
	end

	assign BIAS_PIN_SEL = pin_sel_ff;

	// ==========================================================
	// Display, booster and resistor network enables
	logic                 display_ff;
	logic                 booster_ff;
	logic                 res_bias_ff;
	wire                  nxt_booster;
	wire                  nxt_res_bias;

	// Software must let the booster settle before display on; the booster only starts with the display bit
	assign nxt_booster  = display_bit & (bias_type == BIAS_TYPE_CAP); // RQ7
	assign nxt_res_bias = display_bit & bias_type[1];

	always_ff @(posedge CORE_CLK or negedge NRST) begin
		if (!NRST) begin
			display_ff  <= 1'b0;
			booster_ff  <= 1'b0;
			res_bias_ff <= 1'b0;
		end else begin
			display_ff  <= display_bit; // RQ7
			booster_ff  <= nxt_booster;
			res_bias_ff <= nxt_res_bias;
		end
	end

	assign DISPLAY_ON       = display_ff;
	assign BOOSTER_RUN      = booster_ff;
	assign RESISTOR_BIAS_EN = res_bias_ff;

	// ==========================================================
	// Watch clock synchroniser and edge detect
	logic                 watch_s1_ff;
	logic                 watch_s2_ff;
	logic                 watch_s3_ff;
	logic                 watch_lvl_ff;
	wire                  watch_agree;
	wire                  watch_tick;

	assign watch_agree = (watch_s2_ff == watch_s3_ff);
	assign watch_tick  = watch_agree & watch_s2_ff & ~watch_lvl_ff;

	always_ff @(posedge CORE_CLK or negedge NRST) begin
		if (!NRST) begin
			watch_s1_ff  <= 1'b0;
			watch_s2_ff  <= 1'b0;
			watch_s3_ff  <= 1'b0;
			watch_lvl_ff <= 1'b0;
		end else begin
			watch_s1_ff  <= WATCH_CLK;
			watch_s2_ff  <= watch_s1_ff;
			watch_s3_ff  <= watch_s2_ff;
			watch_lvl_ff <= watch_agree ? watch_s2_ff : watch_lvl_ff;
		end
	end

	// ==========================================================
	// Frame clock divider
	logic [FRAME_DIV_W-1:0] div_cnt_ff;
	logic                   frame_ff;
	wire  [2:0]             tap_sel;
	wire                    nxt_frame;

	// Higher code taps a lower counter bit, so a faster rate
	assign tap_sel   = 3'(FRAME_DIV_W - 1) - {1'b0, frame_code}; // RQ8
	assign nxt_frame = div_cnt_ff[tap_sel];

	always_ff @(posedge CORE_CLK or negedge NRST) begin
		if (!NRST) begin
			div_cnt_ff <= '0;
		end else if (watch_tick) begin
			div_cnt_ff <= div_cnt_ff + 1'b1; // RQ8
		end
	end

	always_ff @(posedge CORE_CLK or negedge NRST) begin
		if (!NRST) begin
			frame_ff <= 1'b0;
		end else begin
			frame_ff <= nxt_frame;
		end
	end

	assign LCD_FRAME_CLK = frame_ff;

	// ==========================================================
	// Assertions
	default clocking cb @(posedge CORE_CLK); endclocking
	default disable iff (!NRST);

	a_duty_half_code: assert property ( // RQ1
		duty_code[2] |=> (DUTY_SEL == DUTY_HALF) && (BIAS_SEL == BIAS_HALF))
		else $error("duty code 1xx not decoded to half duty half bias");

	a_duty_eighth_code: assert property ( // RQ1
		(duty_code == 3'h0) |=> (DUTY_SEL == DUTY_EIGHTH) && (BIAS_SEL == BIAS_QUARTER))
		else $error("duty code 000 not decoded to eighth duty quarter bias");

	a_cap_pin_takeover: assert property ( // RQ2
		(bias_type == BIAS_TYPE_CAP) |=> (BIAS_PIN_SEL == 6'h3F))
		else $error("capacitor bias did not take over all six pins");

	a_res_pin_follow: assert property ( // RQ4
		(bias_type == BIAS_TYPE_RES) |=> (BIAS_PIN_SEL == $past(PORT1_CONFIG_HIGH_LOW)))
		else $error("resistor bias pins do not follow port configuration");

	a_mixed_bias_pins: assert property ( // RQ5
		(bias_type == BIAS_TYPE_MIXED) |=> (BIAS_PIN_SEL[5:2] == 4'hF))
		else $error("mixed bias did not take bias voltage pins");

	a_mixed_cap_pins: assert property ( // RQ6
		(bias_type == BIAS_TYPE_MIXED)
		|=> (BIAS_PIN_SEL[1:0] == $past(PORT1_CONFIG_HIGH_LOW[1:0])))
		else $error("mixed bias took over booster capacitor pins");

	a_booster_start: assert property ( // RQ7
		(display_bit && (bias_type == BIAS_TYPE_CAP)) |=> (DISPLAY_ON && BOOSTER_RUN))
		else $error("booster not running with display on and capacitor bias");

	a_booster_needs_cap: assert property ( // RQ7
		BOOSTER_RUN |-> ($past(bias_type) == BIAS_TYPE_CAP) && $past(display_bit))
		else $error("booster running without display on and capacitor bias");

	a_frame_on_tick: assert property ( // RQ8
		$changed(LCD_FRAME_CLK) && $stable(frame_code)
		|-> $past(watch_tick, 2) || $past(frame_code, 2) != frame_code)
		else $error("frame clock changed without a watch clock tick");

	a_div_step: assert property ( // RQ8
		watch_tick |=> (div_cnt_ff == $past(div_cnt_ff) + 8'h01))
		else $error("frame divider did not advance on watch tick");

endmodule

`default_nettype wire

// ===== hdl/lcd_drive_pkg.sv
// Constants and types for the segment LCD drive control register
//
// Summary of operation
// RQ1: Duty/bias field picks one of five combinations.
// RQ2: Capacitor bias takes over all six port pins.
// RQ3: Software waits 1 ms before display on; the bench waits 100 core cycles.
// RQ4: Resistor bias code 10 leaves pins to config.
// RQ5: Code 11 takes pins 2-5 as bias.
// RQ6: Code 11 leaves booster pins to config.
// RQ7: Display bit on; capacitor bias runs booster.
// RQ8: Top bits pick power-of-two frame clock divide.

`default_nettype none

package lcd_drive_pkg;

	// ==========================================================
	// Register map
	localparam int          ADDR_W           = 8;
	localparam int          DATA_W           = 8;
	localparam logic [7:0]  LCD_CONTROL_ADDR = 8'hFD;
	localparam logic [7:0]  LCD_CONTROL_RST  = 8'h00;

	// ==========================================================
	// Field positions of lcd_control
	localparam int          FRAME_SEL_MSB    = 7;
	localparam int          FRAME_SEL_LSB    = 6;
	localparam int          DUTY_BIAS_MSB    = 5;
	localparam int          DUTY_BIAS_LSB    = 3;
	localparam int          BIAS_TYPE_MSB    = 2;
	localparam int          BIAS_TYPE_LSB    = 1;
	localparam int          DISPLAY_ON_BIT   = 0;

	// ==========================================================
	// Bias type codes
	localparam logic [1:0]  BIAS_TYPE_OFF    = 2'h0;
	localparam logic [1:0]  BIAS_TYPE_CAP    = 2'h1;
	localparam logic [1:0]  BIAS_TYPE_RES    = 2'h2;
	localparam logic [1:0]  BIAS_TYPE_MIXED  = 2'h3;

	// ==========================================================
	// Port pin groups: bits 5..2 bias voltage, 1..0 booster caps
	localparam int          PIN_COUNT        = 6;
	localparam logic [5:0]  PINS_ALL_LCD     = 6'h3F;
	localparam logic [5:0]  PINS_BIAS_ONLY   = 6'h3C;
	localparam logic [5:0]  PINS_CAP_ONLY    = 6'h03;

	// ==========================================================
	// Frame clock divider: watch clock over 2^8 .. 2^5
	localparam int          FRAME_DIV_W      = 8;
	localparam int          FRAME_DIV_MIN_LOG = 5;

	// ==========================================================
	// Core clock
	localparam int          CORE_CLK_PERIOD_NS = 10;

	typedef enum logic [1:0] {DUTY_EIGHTH, DUTY_QUARTER, DUTY_THIRD, DUTY_HALF} duty_t;
	typedef enum logic [1:0] {BIAS_QUARTER, BIAS_THIRD, BIAS_HALF} bias_t;

endpackage

`default_nettype wire

// ===== test/lcd_panel_model.sv
// Watch clock source and frame clock period monitor on the panel side
`timescale 1ns/100ps
`default_nettype none

module lcd_panel_model (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        nrst,
	// Panel side
	input  wire logic        frame_clk,
	output var  logic        watch_clk,
	output var  logic [15:0] period
);
	logic [1:0]  div_ff;
	logic [15:0] cnt_ff;
	logic        last_ff;
	wire         rise = frame_clk & ~last_ff;

	// ==========================================================
	// Watch clock holds each level four core cycles
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			div_ff <= 2'h0;
			watch_clk <= 1'b0;
			cnt_ff <= 16'h0000;
			period <= 16'h0000;
			last_ff <= 1'b0;
		end else begin
			div_ff <= div_ff + 2'h1;
			if (div_ff == 2'h3) watch_clk <= ~watch_clk;
			last_ff <= frame_clk;
			cnt_ff <= rise ? 16'h0001 : cnt_ff + 16'h0001;
			if (rise) period <= cnt_ff;
		end
	end
endmodule

`default_nettype wire

// ===== test/lcd_drive_control_tb_top.sv
// Self-checking bench for the LCD drive control register
`timescale 1ns/100ps
`default_nettype none

module lcd_drive_control_tb_top;
	import lcd_drive_pkg::*;
	logic        clk, nrst, wr, rd, disp, boost, resen, frame, watch;
	logic [7:0]  addr, wdata, rdata, q, d;
	logic [5:0]  cfg, pins;
	logic [15:0] period;
	logic [16:0] lf;
	duty_t       duty;
	bias_t       bias;
	int          num_errors, comparisons;
	// Booster settle wait, scaled down from 1 ms to keep the run short
	localparam int SETTLE_CYCLES = 100;

	lcd_drive_control DUT (.CORE_CLK(clk), .NRST(nrst), .REG_ADDR(addr), .REG_WDATA(wdata),
		.REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata), .WATCH_CLK(watch),
		.PORT1_CONFIG_HIGH_LOW(cfg), .BIAS_PIN_SEL(pins), .DUTY_SEL(duty), .BIAS_SEL(bias),
		.DISPLAY_ON(disp), .BOOSTER_RUN(boost), .RESISTOR_BIAS_EN(resen),
		.LCD_FRAME_CLK(frame));
	lcd_panel_model PANEL (.clk(clk), .nrst(nrst), .frame_clk(frame), .watch_clk(watch),
		.period(period));

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// ==========================================================
	// Expectations
	function automatic logic [16:0] lfsr_next(logic [16:0] x);
		return {x[15:0], x[16] ^ x[13]};
	endfunction

	function automatic logic [12:0] expect_out(logic [7:0] v, logic [5:0] c);
		logic [3:0] db;
		logic [5:0] p;
		db = v[5] ? 4'hE : (v[4:3] == 2'h0) ? 4'h0 : (v[4:3] == 2'h1) ? 4'h5 :
			(v[4:3] == 2'h2) ? 4'h9 : 4'hA;
		case (v[2:1])
			2'h0: p = 6'h00;
			2'h1: p = 6'h3F;
			2'h2: p = c;
			default: p = 6'h3C | (c & 6'h03);
		endcase
		return {db, p, v[0], v[0] & (v[2:1] == 2'h1), v[0] & v[2]};
	endfunction

	// ==========================================================
	// Bus and comparison tasks
	task automatic check(logic [15:0] seen, logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			num_errors++;
			$display("ERROR at %0t ns: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic reg_write(logic [7:0] a, logic [7:0] v);
		@(posedge clk);
		addr <= a;
		wdata <= v;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask

	task automatic reg_read(logic [7:0] a, output logic [7:0] v);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 v = rdata;
	endtask

	task automatic complete_run();
		if (num_errors == 0 && comparisons > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	// ==========================================================
	// Main sequence
	initial begin
		nrst = 1'b0;
		wr = 1'b0;
		rd = 1'b0;
		addr = 8'h00;
		wdata = 8'h00;
		cfg = 6'h00;
		lf = 17'h11A4C;
		repeat (16) @(posedge clk);
		nrst <= 1'b1;
		reg_read(LCD_CONTROL_ADDR, q);
		check(q, LCD_CONTROL_RST);
		for (int i = 0; i < 32; i++) begin
			lf = lfsr_next(lf);
			d = {lf[7:6], i[2:0], i[4:3], lf[0]};
			@(posedge clk);
			cfg <= lf[13:8];
			if ((d[2:1] == BIAS_TYPE_CAP) && d[0]) begin
				reg_write(LCD_CONTROL_ADDR, {d[7:1], 1'b0});
				repeat (SETTLE_CYCLES) @(posedge clk);
			end
			reg_write(LCD_CONTROL_ADDR, d);
			repeat (2) @(posedge clk);
			#1 check({3'h0, duty, bias, pins, disp, boost, resen},
				{3'h0, expect_out(d, cfg)});
			reg_read(LCD_CONTROL_ADDR, q);
			check(q, d);
		end
		// Unmapped address neither stores nor answers
		reg_write(8'hFC, 8'hFF);
		reg_read(8'hFC, q);
		check(q, 8'h00);
		reg_read(LCD_CONTROL_ADDR, q);
		check(q, d);
		// Frame clock period in core cycles, watch clock is 8 core cycles
		for (int c = 0; c < 4; c++) begin
			reg_write(LCD_CONTROL_ADDR, {c[1:0], 6'h01});
			repeat (3 * (8 << (8 - c))) @(posedge clk);
			#1 check(period, 16'(8 << (8 - c)));
		end
		complete_run();
	end

	initial begin
		#400000;
		num_errors++;
		complete_run();
	end
endmodule

`default_nettype wire
